/* File: core/tlp_cycle_div.sv */
`timescale 1ns/10ps
module tlp_cycle_div
    import tlp_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic nrst,
    // Instruction cycle strobe.
    output logic instr_en
);

    // ************************************************************
    // Instruction cycle divider.
    // ************************************************************
    localparam logic [1:0] DIV_LAST = 2'(CLK_PER_INSTR - 1);

    logic [1:0] div_r;
    logic [1:0] div_nxt;
    logic instr_en_r;
    logic instr_en_nxt;

    // The strobe marks the last clock of every instruction cycle.
    always_comb begin
        div_nxt = (div_r == DIV_LAST) ? 2'h0 : div_r + 2'h1;
        instr_en_nxt = (div_nxt == DIV_LAST);
    end

    // Registered so the strobe is glitch free.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            div_r <= 2'h0;
            instr_en_r <= 1'b0;
        end else begin
            div_r <= div_nxt;
            instr_en_r <= instr_en_nxt;
        end
    end

    assign instr_en = instr_en_r;

endmodule

/* File: core/tlp_flag_bank.sv */
`timescale 1ns/10ps
module tlp_flag_bank
    import tlp_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic nrst,
    // Source events, one pulse per event.
    input wire logic [NSRC-1:0] src_event,
    // Software writes to the two flag bytes.
    input wire logic wr_lo,
    input wire logic wr_hi,
    input wire logic [DATA_W-1:0] wdata,
    // Current flags.
    output logic [NSRC-1:0] flags
);

    // ************************************************************
    // One sticky flag per source.
    // ************************************************************
    logic [NSRC-1:0] flag_r;
    logic [NSRC-1:0] flag_nxt;

    genvar g;
    generate
        for (g = 0; g < NSRC; g++) begin : g_flag
            logic wr_this;
            assign wr_this = (g < DATA_W) ? wr_lo : wr_hi;
            // An event in the same cycle as a software clear wins, so no event is lost.
            always_comb begin
                flag_nxt[g] = (wr_this ? wdata[g % DATA_W] : flag_r[g]) | src_event[g];
            end
        end
    endgenerate

    // Flags only ever fall by a software write.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            flag_r <= '0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    assign flags = flag_r;

endmodule

/* File: core/tlp_irq_ctrl.sv */
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
module tlp_irq_ctrl
    import tlp_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic nrst,
    // Register port.
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // Interrupt sources.
    input wire logic [NSRC-1:0] src_event,
    // Processor core.
    input wire logic return_from_irq_instr,
    output tlp_vec_s vec_out,
    output logic wake_out
);

    // ************************************************************
    // Address decoding.
    // ************************************************************

    // True when a strobe addresses the register at the given offset.
    function automatic logic reg_hit(input logic strobe, input logic [ADDR_W-1:0] addr,
                                     input logic [7:0] off);
        reg_hit = strobe && (addr == off);
    endfunction

    logic wr_reset_control;
    logic wr_irq_control;
    logic wr_flag_lo;
    logic wr_flag_hi;
    logic wr_en_lo;
    logic wr_en_hi;
    logic wr_pri_lo;
    logic wr_pri_hi;

    // One write decode per writable register.
    always_comb begin
        wr_reset_control = reg_hit(reg_wr, reg_addr, OFF_RESET_CONTROL);
        wr_irq_control = reg_hit(reg_wr, reg_addr, OFF_IRQ_CONTROL);
        wr_flag_lo = reg_hit(reg_wr, reg_addr, OFF_FLAG_LO);
        wr_flag_hi = reg_hit(reg_wr, reg_addr, OFF_FLAG_HI);
        wr_en_lo = reg_hit(reg_wr, reg_addr, OFF_ENABLE_LO);
        wr_en_hi = reg_hit(reg_wr, reg_addr, OFF_ENABLE_HI);
        wr_pri_lo = reg_hit(reg_wr, reg_addr, OFF_PRIORITY_LO);
        wr_pri_hi = reg_hit(reg_wr, reg_addr, OFF_PRIORITY_HI);
    end

    // ************************************************************
    // Submodules: instruction cycle strobe and flag bank.
    // ************************************************************
    logic instr_en;
    logic [NSRC-1:0] flags;

    tlp_cycle_div u_div (
        .core_clk(core_clk),
        .nrst(nrst),
        .instr_en(instr_en)
    );

    tlp_flag_bank u_flags (
        .core_clk(core_clk),
        .nrst(nrst),
        .src_event(src_event),
        .wr_lo(wr_flag_lo),
        .wr_hi(wr_flag_hi),
        .wdata(reg_wdata),
        .flags(flags)
    );

    // ************************************************************
    // Control registers and their next values.
    // ************************************************************
    logic priority_mode_enable_r;
    logic priority_mode_enable_nxt;
    logic high_group_enable_r;
    logic high_group_enable_nxt;
    logic low_group_enable_r;
    logic low_group_enable_nxt;
    logic [NSRC-1:0] src_enable_r;
    logic [NSRC-1:0] src_enable_nxt;
    logic [NSRC-1:0] src_priority_r;
    logic [NSRC-1:0] src_priority_nxt;
    logic high_active_r;
    logic high_active_nxt;
    logic low_active_r;
    logic low_active_nxt;

    // ************************************************************
    // Request admission.
    // ************************************************************
    logic [NSRC-1:0] armed;
    logic compat_req;
    logic high_req;
    logic low_req;
    logic want_high;
    logic want_low;
    logic any_req;

    // In compatibility mode bit 7 is the single global enable and bit 6 the
    // peripheral group; in priority mode they become the high and low groups.
    always_comb begin
        armed = flags & src_enable_r;
        compat_req = high_group_enable_r
            && |(armed & (CORE_SRC_MASK | (low_group_enable_r ? ~CORE_SRC_MASK : 16'h0000)));
        high_req = high_group_enable_r && |(armed & src_priority_r);
        low_req = high_group_enable_r && low_group_enable_r && !high_active_r
            && |(armed & ~src_priority_r);
        if (priority_mode_enable_r) begin
            want_high = high_req;
            want_low = low_req && !high_req;
        end else begin
            want_high = compat_req;
            want_low = 1'b0;
        end
        any_req = want_high || want_low;
    end

    // ************************************************************
    // Vectoring sequencer.
    // ************************************************************
    tlp_state_e state_r;
    tlp_state_e state_nxt;
    logic [1:0] lat_cnt_r;
    logic [1:0] lat_cnt_nxt;
    logic take_now;

    // A request waits out whole instruction cycles before it is taken. Because
    // it arrives at any point inside a cycle, the total comes to three to four
    // instruction cycles whatever instruction was running.
    always_comb begin
        state_nxt = state_r;
        lat_cnt_nxt = lat_cnt_r;
        take_now = 1'b0;
        case (state_r)
            ST_IDLE: begin
                lat_cnt_nxt = 2'h0;
                if (any_req) begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!any_req) begin
                    state_nxt = ST_IDLE; // Enable withdrawn before the vector.
                end else if (instr_en) begin
                    lat_cnt_nxt = lat_cnt_r + 2'h1;
                    if (lat_cnt_r == LATENCY_INSTR - 2'h1) begin
                        state_nxt = ST_TAKE;
                    end
                end
            end
            ST_TAKE: begin
                take_now = any_req;
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // ************************************************************
    // Control register update.
    // ************************************************************

    // Software writes come first, then the return instruction, and a take in
    // the same cycle has the last word so an accepted interrupt is never left
    // with its group enable still set.
    always_comb begin
        priority_mode_enable_nxt = priority_mode_enable_r;
        high_group_enable_nxt = high_group_enable_r;
        low_group_enable_nxt = low_group_enable_r;
        src_enable_nxt = src_enable_r;
        src_priority_nxt = src_priority_r;
        high_active_nxt = high_active_r;
        low_active_nxt = low_active_r;
        if (wr_reset_control) begin
            priority_mode_enable_nxt = reg_wdata[BIT_PRIORITY_MODE];
        end
        if (wr_irq_control) begin
            high_group_enable_nxt = reg_wdata[BIT_HIGH_GROUP];
            low_group_enable_nxt = reg_wdata[BIT_LOW_GROUP];
        end
        if (wr_en_lo) begin
            src_enable_nxt[7:0] = reg_wdata;
        end
        if (wr_en_hi) begin
            src_enable_nxt[15:8] = reg_wdata;
        end
        if (wr_pri_lo) begin
            src_priority_nxt[7:0] = reg_wdata;
        end
        if (wr_pri_hi) begin
            src_priority_nxt[15:8] = reg_wdata;
        end
        if (return_from_irq_instr) begin
            if (!priority_mode_enable_r) begin
                high_group_enable_nxt = 1'b1;
                high_active_nxt = 1'b0;
            end else if (high_active_r) begin
                high_group_enable_nxt = 1'b1;
                high_active_nxt = 1'b0;
            end else if (low_active_r) begin
                low_group_enable_nxt = 1'b1;
                low_active_nxt = 1'b0;
            end
        end
        if (take_now) begin
            if (want_high) begin
                high_group_enable_nxt = 1'b0;
                high_active_nxt = 1'b1;
            end else begin
                low_group_enable_nxt = 1'b0;
                low_active_nxt = 1'b1;
            end
        end
    end

    // ************************************************************
    // Outputs to the core and register read data.
    // ************************************************************
    tlp_vec_s vec_r;
    tlp_vec_s vec_nxt;
    logic wake_r;
    logic wake_nxt;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;

    // The take pulse tells the core to push its return address and load the
    // vector. Flags are left alone; the routine polls and clears them itself.
    always_comb begin
        vec_nxt = '0;
        vec_nxt.take = take_now;
        vec_nxt.stack_push = take_now;
        vec_nxt.pc_load = take_now;
        vec_nxt.high_level = take_now && want_high;
        if (take_now) begin
            vec_nxt.vector = want_high ? VEC_HIGH : VEC_LOW;
        end
        wake_nxt = |armed;
    end

    // Read data appear in the cycle after the strobe; unmapped offsets read zero.
    always_comb begin
        rdata_nxt = '0;
        if (!reg_rd) begin
            rdata_nxt = '0;
        end else if (reg_addr == OFF_RESET_CONTROL) begin
            rdata_nxt[BIT_PRIORITY_MODE] = priority_mode_enable_r;
        end else if (reg_addr == OFF_IRQ_CONTROL) begin
            rdata_nxt[BIT_HIGH_GROUP] = high_group_enable_r;
            rdata_nxt[BIT_LOW_GROUP] = low_group_enable_r;
        end else if (reg_addr == OFF_FLAG_LO) begin
            rdata_nxt = flags[7:0];
        end else if (reg_addr == OFF_FLAG_HI) begin
            rdata_nxt = flags[15:8];
        end else if (reg_addr == OFF_ENABLE_LO) begin
            rdata_nxt = src_enable_r[7:0];
        end else if (reg_addr == OFF_ENABLE_HI) begin
            rdata_nxt = src_enable_r[15:8];
        end else if (reg_addr == OFF_PRIORITY_LO) begin
            rdata_nxt = src_priority_r[7:0];
        end else if (reg_addr == OFF_PRIORITY_HI) begin
            rdata_nxt = src_priority_r[15:8];
        end else if (reg_addr == OFF_STATUS) begin
            rdata_nxt[BIT_ST_HIGH_ACTIVE] = high_active_r;
            rdata_nxt[BIT_ST_LOW_ACTIVE] = low_active_r;
            rdata_nxt[BIT_ST_WAKE] = wake_r;
        end
    end

    // ************************************************************
    // State registers.
    // ************************************************************

    // Reset leaves compatibility mode, all groups off and nothing in service.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            priority_mode_enable_r <= 1'b0;
            high_group_enable_r <= 1'b0;
            low_group_enable_r <= 1'b0;
            src_enable_r <= RST_ENABLE;
            src_priority_r <= RST_PRIORITY;
            high_active_r <= 1'b0;
            low_active_r <= 1'b0;
            state_r <= ST_IDLE;
            lat_cnt_r <= 2'h0;
            vec_r <= '0;
            wake_r <= 1'b0;
            rdata_r <= '0;
        end else begin
            priority_mode_enable_r <= priority_mode_enable_nxt;
            high_group_enable_r <= high_group_enable_nxt;
            low_group_enable_r <= low_group_enable_nxt;
            src_enable_r <= src_enable_nxt;
            src_priority_r <= src_priority_nxt;
            high_active_r <= high_active_nxt;
            low_active_r <= low_active_nxt;
            state_r <= state_nxt;
            lat_cnt_r <= lat_cnt_nxt;
            vec_r <= vec_nxt;
            wake_r <= wake_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign vec_out = vec_r;
    assign wake_out = wake_r;

endmodule

/* File: core/tlp_pkg.sv */
package tlp_pkg;

    // ************************************************************
    // Sizes of the register port and of the source set.
    // ************************************************************
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned NSRC = 16;
    localparam int unsigned PC_W = 16;

    // ************************************************************
    // Register offsets on the plain register port.
    // ************************************************************
    localparam logic [7:0] OFF_RESET_CONTROL = 8'h00;
    localparam logic [7:0] OFF_IRQ_CONTROL = 8'h01;
    localparam logic [7:0] OFF_FLAG_LO = 8'h02;
    localparam logic [7:0] OFF_FLAG_HI = 8'h03;
    localparam logic [7:0] OFF_ENABLE_LO = 8'h04;
    localparam logic [7:0] OFF_ENABLE_HI = 8'h05;
    localparam logic [7:0] OFF_PRIORITY_LO = 8'h06;
    localparam logic [7:0] OFF_PRIORITY_HI = 8'h07;
    localparam logic [7:0] OFF_STATUS = 8'h08;

    // ************************************************************
    // Field positions and reset values.
    // ************************************************************
    localparam int unsigned BIT_PRIORITY_MODE = 7;
    localparam int unsigned BIT_HIGH_GROUP = 7;
    localparam int unsigned BIT_LOW_GROUP = 6;
    localparam int unsigned BIT_ST_HIGH_ACTIVE = 0;
    localparam int unsigned BIT_ST_LOW_ACTIVE = 1;
    localparam int unsigned BIT_ST_WAKE = 2;
    localparam logic [15:0] RST_ENABLE = 16'h0000;
    localparam logic [15:0] RST_PRIORITY = 16'hffff;
    localparam logic [15:0] CORE_SRC_MASK = 16'h00ff;

    // ************************************************************
    // Vectors and timing counts.
    // ************************************************************
    localparam logic [15:0] VEC_HIGH = 16'h0008;
    localparam logic [15:0] VEC_LOW = 16'h0018;
    localparam int unsigned CLK_PER_INSTR = 4;
    localparam logic [1:0] LATENCY_INSTR = 2'h3;

    // One-hot states of the vectoring sequencer.
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_TAKE = 3'b100
    } tlp_state_e;

    // Vector request handed to the processor core.
    typedef struct packed {
        logic take;
        logic high_level;
        logic stack_push;
        logic pc_load;
        logic [PC_W-1:0] vector;
    } tlp_vec_s;

endpackage

/* File: verification/test_tlp_irq_ctrl.sv */
`timescale 1ns/10ps
module test_tlp_irq_ctrl
    import tlp_pkg::*;
;
    logic core_clk, nrst, reg_wr, reg_rd, ret, ret_req, wake_out;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
    logic [15:0] src_event, exp_f, m;
    logic [3:0] ret_delay, depth;
    tlp_vec_s vec_out;
    integer err_count, checks_done, cyc, take_cnt, seed, lat;
    logic [7:0] ra [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h5a};
    logic [7:0] re [11] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00};

    tlp_irq_ctrl i_tlp_irq_ctrl (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_event(src_event),
        .return_from_irq_instr(ret), .vec_out(vec_out), .wake_out(wake_out));
    tlp_core_model i_tlp_core_model (.core_clk(core_clk), .nrst(nrst), .vec_out(vec_out), .ret_req(ret_req),
        .ret_delay(ret_delay), .return_from_irq_instr(ret), .depth(depth));

    // ************************************************************
    // Clock, take counter and hang guard.
    // ************************************************************
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // Takes are counted so that silent spurious vectors still show up.
    always @(posedge core_clk) begin
        cyc = cyc + 1;
        if (vec_out.take === 1'b1) take_cnt = take_cnt + 1;
        if (cyc == 20000) begin
            err_count = err_count + 1;
            conclude();
        end
    end

    // ************************************************************
    // Bench tasks.
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Single register writes only, never a multi-register move.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask

    // Read data stands only in the cycle after the strobe, so it is sampled there.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge core_clk);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] msk);
        rd(a, v);
        check(v & msk, e);
    endtask

    task automatic evt(input logic [15:0] mask);
        src_event <= mask;
        @(posedge core_clk);
        src_event <= 16'h0000;
        @(posedge core_clk);
    endtask

    // Waits a bounded time for a take and compares its vector.
    task automatic take_chk(input logic [15:0] e);
        lat = 0;
        do begin
            @(posedge core_clk);
            #1 lat = lat + 1;
        end while (vec_out.take !== 1'b1 && lat < 40);
        check(vec_out.take, 1'b1);
        check(vec_out.vector, e);
    endtask

    task automatic no_take(input integer n);
        integer c0;
        c0 = take_cnt;
        repeat (n) @(posedge core_clk);
        #1 check(take_cnt - c0, 0);
    endtask

    task automatic ret_irq;
        integer k;
        k = 0;
        ret_delay <= 4'($random(seed) & 7);
        ret_req <= 1'b1;
        @(posedge core_clk);
        ret_req <= 1'b0;
        while (ret !== 1'b1 && k < 20) begin
            @(posedge core_clk);
            #1 k = k + 1;
        end
        @(posedge core_clk);
    endtask

    function automatic logic [15:0] exp_vec(input logic mode, input logic hi);
        return (mode && !hi) ? VEC_LOW : VEC_HIGH;
    endfunction

    task automatic conclude;
        if (err_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // ************************************************************
    // Main sequence.
    // ************************************************************
    initial begin
        {nrst, reg_wr, reg_rd, ret_req, reg_addr, reg_wdata, src_event, ret_delay} = '0;
        {err_count, checks_done, cyc, take_cnt} = '0;
        seed = 32'h784ffc5f;
        repeat (12) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        for (int i = 0; i < 11; i++) rd_chk(ra[i], re[i], 8'hff);
        // Random events with every enable off set flags but never vector.
        exp_f = 16'h0000;
        repeat (6) begin
            m = 16'($random(seed));
            evt(m);
            exp_f = exp_f | m;
        end
        rd_chk(OFF_FLAG_LO, exp_f[7:0], 8'hff);
        rd_chk(OFF_FLAG_HI, exp_f[15:8], 8'hff);
        check(take_cnt, 0);
        check(wake_out, 1'b0);
        wr(OFF_FLAG_LO, 8'h00);
        wr(OFF_FLAG_HI, 8'h00);
        rd_chk(OFF_FLAG_LO, 8'h00, 8'hff);
        // Compatibility mode, core source 3.
        wr(OFF_ENABLE_LO, 8'h08);
        wr(OFF_IRQ_CONTROL, 8'h80);
        evt(16'h0008);
        take_chk(exp_vec(1'b0, 1'b1));
        // The event cycle starts two edges before lat begins to count.
        check(lat >= 3 * CLK_PER_INSTR - 2 && lat <= 4 * CLK_PER_INSTR - 2, 1'b1);
        rd_chk(OFF_IRQ_CONTROL, 8'h00, 8'hc0);
        rd_chk(OFF_FLAG_LO, 8'h08, 8'hff);
        rd_chk(OFF_STATUS, 8'h01, 8'h01);
        check(wake_out, 1'b1);
        wr(OFF_FLAG_LO, 8'h00);
        ret_irq();
        rd_chk(OFF_IRQ_CONTROL, 8'h80, 8'hc0);
        check(depth, 4'h0);
        // Peripheral source 9 needs the peripheral group enable.
        wr(OFF_ENABLE_HI, 8'h02);
        evt(16'h0200);
        no_take(24);
        wr(OFF_IRQ_CONTROL, 8'hc0);
        take_chk(exp_vec(1'b0, 1'b0));
        rd_chk(OFF_IRQ_CONTROL, 8'h40, 8'hc0);
        wr(OFF_FLAG_HI, 8'h00);
        ret_irq();
        wr(OFF_ENABLE_HI, 8'h00);
        // Priority mode: source 2 low level, source 5 high level.
        wr(OFF_RESET_CONTROL, 8'h80);
        rd_chk(OFF_RESET_CONTROL, 8'h80, 8'h80);
        wr(OFF_ENABLE_LO, 8'h24);
        wr(OFF_PRIORITY_LO, 8'hfb);
        wr(OFF_IRQ_CONTROL, 8'h40);
        evt(16'h0004);
        no_take(24);
        wr(OFF_IRQ_CONTROL, 8'hc0);
        take_chk(exp_vec(1'b1, 1'b0));
        rd_chk(OFF_IRQ_CONTROL, 8'h80, 8'hc0);
        evt(16'h0020);
        take_chk(exp_vec(1'b1, 1'b1));
        rd_chk(OFF_IRQ_CONTROL, 8'h00, 8'hc0);
        rd_chk(OFF_STATUS, 8'h03, 8'h03);
        // Low flag still pending while the high routine runs.
        wr(OFF_FLAG_LO, 8'h04);
        wr(OFF_IRQ_CONTROL, 8'hc0);
        no_take(24);
        ret_irq();
        take_chk(exp_vec(1'b1, 1'b0));
        wr(OFF_FLAG_LO, 8'h00);
        ret_irq();
        rd_chk(OFF_IRQ_CONTROL, 8'hc0, 8'hc0);
        // Both levels raised together: the high one goes first.
        evt(16'h0024);
        take_chk(exp_vec(1'b1, 1'b1));
        wr(OFF_FLAG_LO, 8'h00);
        ret_irq();
        rd_chk(OFF_IRQ_CONTROL, 8'hc0, 8'hc0);
        no_take(24);
        conclude();
    end
endmodule

/* File: verification/tlp_core_model.sv */
`timescale 1ns/10ps
module tlp_core_model
    import tlp_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic nrst,
    // Vector from the controller and return command from the bench.
    input wire tlp_vec_s vec_out,
    input wire logic ret_req,
    input wire logic [3:0] ret_delay,
    // Return pulse and stack depth.
    output logic return_from_irq_instr,
    output logic [3:0] depth
);
    logic [4:0] cnt;

    // The routine ends some cycles after the bench asks, so slow and prompt returns both occur.
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            depth <= 4'h0;
            cnt <= 5'h00;
            return_from_irq_instr <= 1'b0;
        end else begin
            return_from_irq_instr <= 1'b0;
            if (ret_req && cnt == 5'h00) begin
                cnt <= {1'b0, ret_delay} + 5'h01;
            end else if (cnt == 5'h01) begin
                cnt <= 5'h00;
                return_from_irq_instr <= 1'b1;
            end else if (cnt != 5'h00) begin
                cnt <= cnt - 5'h01;
            end
            depth <= depth + {3'h0, vec_out.take} - {3'h0, cnt == 5'h01};
        end
    end
endmodule

/* File: verification/tlp_irq_ctrl_assertions.sv */
`timescale 1ns/10ps
module tlp_irq_ctrl_chk
    import tlp_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic nrst,
    // Register port.
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    // Sources and processor core.
    input wire logic [NSRC-1:0] src_event,
    input wire logic return_from_irq_instr,
    input wire tlp_vec_s vec_out,
    input wire logic wake_out
);
    // ************************************************************
    // Shadow of the priority-mode bit, only software changes it.
    // ************************************************************
    logic mode_r;
    logic mode_nxt;

    // Next value follows writes to the reset control register.
    always_comb begin
        mode_nxt = mode_r;
        if (reg_wr && reg_addr == OFF_RESET_CONTROL) begin
            mode_nxt = reg_wdata[BIT_PRIORITY_MODE];
        end
    end

    // Register the shadow.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mode_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    // ************************************************************
    // Properties on the vector link and the register port.
    // ************************************************************
    property p_take_single;
        vec_out.take |=> !vec_out.take [*8];
    endproperty
    a_take_single: assert property (p_take_single) else $error("second vector too soon after a take");

    property p_take_fields;
        vec_out.take |-> vec_out.stack_push && vec_out.pc_load;
    endproperty
    a_take_fields: assert property (p_take_fields) else $error("take without push and load");

    property p_vec_addr;
        vec_out.take |-> vec_out.vector == (vec_out.high_level ? VEC_HIGH : VEC_LOW);
    endproperty
    a_vec_addr: assert property (p_vec_addr) else $error("vector address does not match level");

    property p_vec_quiet;
        !vec_out.take |-> vec_out.vector == 16'h0000 && !vec_out.stack_push && !vec_out.pc_load;
    endproperty
    a_vec_quiet: assert property (p_vec_quiet) else $error("vector fields active without take");

    property p_compat_vec;
        vec_out.take && !mode_r |-> vec_out.vector == VEC_HIGH;
    endproperty
    a_compat_vec: assert property (p_compat_vec) else $error("compatibility vector not the high one");

    property p_rdata_idle;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");

    property p_unmapped;
        reg_rd && reg_addr > OFF_STATUS |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    property p_mode_read;
        reg_rd && reg_addr == OFF_RESET_CONTROL |=> reg_rdata[BIT_PRIORITY_MODE] == mode_r;
    endproperty
    a_mode_read: assert property (p_mode_read) else $error("priority mode bit reads wrong");
endmodule

bind tlp_irq_ctrl tlp_irq_ctrl_chk i_tlp_irq_ctrl_chk (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_event(src_event),
    .return_from_irq_instr(return_from_irq_instr), .vec_out(vec_out), .wake_out(wake_out));
